/* File: rtl/rpa_regs.svh */
// Purpose: offsets, field positions and timing counts
// Assumes: word register port, byte offsets
// Notes: definitions only
`ifndef RPA_REGS_SVH
`define RPA_REGS_SVH
`define RPA_TASK_TX_RAMP 12'h000
`define RPA_TASK_RX_RAMP 12'h004
`define RPA_TASK_START 12'h008
`define RPA_TASK_STOP 12'h00C
`define RPA_TASK_DISABLE 12'h010
`define RPA_TASK_SS_START 12'h014
`define RPA_TASK_BC_START 12'h01C
`define RPA_TASK_BC_STOP 12'h020
`define RPA_EVT_STATUS 12'h100
`define RPA_SHORTCUTS 12'h200
`define RPA_PKT_PTR 12'h504
`define RPA_MODE 12'h510
`define RPA_PKT_CFG_A 12'h514
`define RPA_PKT_CFG_B 12'h518
`define RPA_IFS 12'h544
`define RPA_SS_VALUE 12'h548
`define RPA_BC_CMP 12'h560
`define RPA_DEV_LOW 12'h600
`define RPA_DEV_HIGH 12'h620
`define RPA_DEV_CFG 12'h640
`define RPA_ACTIVE_MODE 12'h700
`define RPA_PKT_PTR_ACT 12'h704
`define RPA_PLAN 12'h708
// shortcut bits
`define RPA_SC_END_DIS 1
`define RPA_SC_DIS_TX 2
`define RPA_SC_DIS_RX 3
// packet config a fields
`define RPA_LF_LSB 0
`define RPA_S0_BIT 8
`define RPA_S1_LSB 16
// packet config b fields
`define RPA_MAX_LSB 0
`define RPA_STAT_LSB 8
`define RPA_ENDIAN_BIT 24
// header bit that holds the address type
`define RPA_TYPE_BIT 6
// event status bits
`define RPA_EV_END 0
`define RPA_EV_DIS 1
`define RPA_EV_DMATCH 2
`define RPA_EV_DMISS 3
`define RPA_EV_SSEND 4
`define RPA_EV_BCM 5
// timing in ns, cycle counts and turnaround in us
`define RPA_CLK_NS 25
`define RPA_US_NS 1000
`define RPA_US_CYC ((`RPA_US_NS + `RPA_CLK_NS - 1) / `RPA_CLK_NS)
`define RPA_SS_PERIOD_NS 250
`define RPA_SS_CYC ((`RPA_SS_PERIOD_NS + `RPA_CLK_NS - 1) / `RPA_CLK_NS)
`define RPA_TURN_US 16'd40
`endif

/* File: rtl/rpa_pkg.sv */
// Purpose: shared types
// Assumes: nothing
// Notes: none
package rpa_pkg;
  typedef enum logic [1:0] {RPA_IDLE, RPA_GAP, RPA_TXGO} rpa_ifs_t;
  typedef logic [47:0] rpa_addr_t;
endpackage

/* File: rtl/rpa_engine.sv */
// Purpose: auxiliary packet logic of a radio: strength sample, spacing,
//   address match, bit counter, packet layout planner
// Assumes: modem bit stream on mclk, one bit strobe per air bit
// Notes: registers on a plain word port, read data one cycle after strobe
// What this block does
// - filtered signal strength sampled on task, readable after sample period
// - gap from last received bit to first sent bit equals spacing value, at least 40 us
// - spacing enforced only with end-to-disable and disabled-to-ramp shortcuts
// - shortcut and spacing registers act directly, no double buffering
// - data rate setting copied to active copy on either ramp task
// - address match only while receiving and little endian configured
// - first 48 payload bits are address, header bit 6 is type
// - eight entries: 32 low bits, 16 high bits, type bit each
// - each entry has its own enable bit
// - bit counter starts and stops on tasks, match event at compare
// - counting continues after match; new compare gives new matches
// - stop task, stop, disable or end clear the counter
// - one packet pointer, double buffered, taken at start
// - image order header a, length, header b, payload; add-on follows
// - fields take whole bytes; zero width takes none
// - widths from config, payload count from stored length value
// - payload plus add-on capped at maximum, headers excluded
// - length field untouched; crc length reported as maximum when capped, else length value
// - end event after last bit, disabled event acknowledges disable
// - one strength sample per strength start task
module rpa_engine #(
  parameter int NUM_ADDR = 8,
  parameter int SS_W = 7,
  parameter int BC_W = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [SS_W-1:0] ss_level,
  input wire logic receiving,
  input wire logic bit_strobe,
  input wire logic rx_bit,
  input wire logic addr_event,
  input wire logic payload_start,
  input wire logic last_bit,
  input wire logic disable_done,
  input wire logic [7:0] length_value,
  input wire logic length_valid,
  output logic tx_first_bit,
  output logic end_event,
  output logic disabled_event,
  output logic bitcount_match_event,
  output logic dev_match,
  output logic dev_miss,
  output logic [7:0] crc_length,
  output logic [31:0] active_ptr
);
  import rpa_pkg::*;
`include "rpa_regs.svh"
  initial begin
    if (NUM_ADDR < 1 || NUM_ADDR > 8 || SS_W < 1 || SS_W > 16 || BC_W < 8 || BC_W > 32)
      $error("rpa_engine: unsupported parameter");
  end

  // synchronise the async strength level input
  logic [SS_W-1:0] ss_s1_r, ss_s2_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ss_s1_r <= '0;
      ss_s2_r <= '0;
    end else begin
      ss_s1_r <= ss_level;
      ss_s2_r <= ss_s1_r;
    end
  end

  // register writes
  wire wr_tx = reg_wr && reg_addr == `RPA_TASK_TX_RAMP;
  wire wr_rx = reg_wr && reg_addr == `RPA_TASK_RX_RAMP;
  wire wr_start = reg_wr && reg_addr == `RPA_TASK_START;
  wire wr_stop = reg_wr && reg_addr == `RPA_TASK_STOP;
  wire wr_dis = reg_wr && reg_addr == `RPA_TASK_DISABLE;
  wire wr_ss = reg_wr && reg_addr == `RPA_TASK_SS_START;
  wire wr_bcs = reg_wr && reg_addr == `RPA_TASK_BC_START;
  wire wr_bcp = reg_wr && reg_addr == `RPA_TASK_BC_STOP;
  wire wr_evt = reg_wr && reg_addr == `RPA_EVT_STATUS;
  wire dev_lo_sel = reg_addr[11:5] == 7'(`RPA_DEV_LOW >> 5);
  wire dev_hi_sel = reg_addr[11:5] == 7'(`RPA_DEV_HIGH >> 5);
  wire [2:0] dev_idx = reg_addr[4:2];

  logic [3:0] shortcut_enables_r;
  logic [15:0] interframe_spacing_r;
  logic [31:0] mode_r, mode_act_r, ptr_r, ptr_act_r;
  logic [31:0] packet_config_a_r, packet_config_b_r;
  logic [BC_W-1:0] bitcount_compare_r;
  logic [31:0] dev_addr_low_part_r [NUM_ADDR];
  logic [15:0] dev_addr_high_part_r [NUM_ADDR];
  logic [15:0] dev_match_config_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shortcut_enables_r <= 4'h0;
      interframe_spacing_r <= 16'h0000;
      mode_r <= 32'h0;
      ptr_r <= 32'h0;
      packet_config_a_r <= 32'h0;
      packet_config_b_r <= 32'h0;
      bitcount_compare_r <= '0;
      dev_match_config_r <= 16'h0000;
    end else if (reg_wr) begin
      // used directly by the spacing logic
      if (reg_addr == `RPA_SHORTCUTS) shortcut_enables_r <= reg_wdata[3:0];
      if (reg_addr == `RPA_IFS) interframe_spacing_r <= reg_wdata[15:0];
      if (reg_addr == `RPA_MODE) mode_r <= reg_wdata;
      // pending pointer
      if (reg_addr == `RPA_PKT_PTR) ptr_r <= reg_wdata;
      if (reg_addr == `RPA_PKT_CFG_A) packet_config_a_r <= reg_wdata;
      if (reg_addr == `RPA_PKT_CFG_B) packet_config_b_r <= reg_wdata;
      if (reg_addr == `RPA_BC_CMP) bitcount_compare_r <= reg_wdata[BC_W-1:0];
      if (reg_addr == `RPA_DEV_CFG) dev_match_config_r <= reg_wdata[15:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (reg_wr && dev_lo_sel && 32'(dev_idx) < NUM_ADDR)
      dev_addr_low_part_r[dev_idx] <= reg_wdata;
    if (reg_wr && dev_hi_sel && 32'(dev_idx) < NUM_ADDR)
      dev_addr_high_part_r[dev_idx] <= reg_wdata[15:0];
  end
  // active copies taken on ramp and start tasks
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_act_r <= 32'h0;
      ptr_act_r <= 32'h0;
    end else begin
      if (wr_tx || wr_rx) mode_act_r <= mode_r;
      if (wr_start) ptr_act_r <= ptr_r;
    end
  end

  // strength sample, one per task
  logic [SS_W-1:0] ss_filt_r, ss_value_r;
  logic [7:0] ss_cnt_r;
  logic ss_busy_r, ss_done_r;
  wire [SS_W+1:0] ss_sum = ({2'b00, ss_filt_r} << 1) + {2'b00, ss_filt_r} + {2'b00, ss_s2_r};
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ss_filt_r <= '0;
      ss_value_r <= '0;
      ss_cnt_r <= 8'h00;
      ss_busy_r <= 1'b0;
      ss_done_r <= 1'b0;
    end else begin
      ss_filt_r <= ss_sum[SS_W+1:2]; // single pole
      ss_done_r <= 1'b0;
      if (wr_ss) begin
        ss_busy_r <= 1'b1;
        ss_cnt_r <= 8'(`RPA_SS_CYC);
      end else if (ss_busy_r) begin
        if (ss_cnt_r == 8'h01) begin
          ss_busy_r <= 1'b0; // single shot
          ss_value_r <= ss_filt_r;
          ss_done_r <= 1'b1;
        end
        ss_cnt_r <= ss_cnt_r - 8'h01;
      end
    end
  end

  // interframe spacing
  wire ifs_on = shortcut_enables_r[`RPA_SC_END_DIS] &&
    (shortcut_enables_r[`RPA_SC_DIS_TX] || shortcut_enables_r[`RPA_SC_DIS_RX]);
  wire [15:0] gap_us = interframe_spacing_r < `RPA_TURN_US ? `RPA_TURN_US
    : interframe_spacing_r;
  rpa_ifs_t ifs_r;
  logic [15:0] us_left_r;
  logic [7:0] tick_r;
  logic tx_first_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ifs_r <= RPA_IDLE;
      us_left_r <= 16'h0000;
      tick_r <= 8'h00;
      tx_first_r <= 1'b0;
    end else begin
      tx_first_r <= 1'b0;
      case (ifs_r)
        RPA_IDLE: if (last_bit && receiving && ifs_on) begin
          ifs_r <= RPA_GAP;
          us_left_r <= gap_us;
          tick_r <= 8'(`RPA_US_CYC - 1);
        end
        RPA_GAP: begin
          if (tick_r == 8'h00) begin
            tick_r <= 8'(`RPA_US_CYC - 1);
            us_left_r <= us_left_r - 16'h0001;
            if (us_left_r == 16'h0001) ifs_r <= RPA_TXGO;
          end else begin
            tick_r <= tick_r - 8'h01;
          end
        end
        RPA_TXGO: begin
          tx_first_r <= 1'b1;
          ifs_r <= RPA_IDLE;
        end
        default: ifs_r <= RPA_IDLE;
      endcase
    end
  end

  logic [4:0] hdr_cnt_r;
  logic hdr_run_r;
  wire hdr_strobe_6 = hdr_run_r && bit_strobe && hdr_cnt_r == 5'(`RPA_TYPE_BIT);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hdr_cnt_r <= 5'h00;
      hdr_run_r <= 1'b0;
    end else if (addr_event) begin
      hdr_cnt_r <= 5'h00;
      hdr_run_r <= 1'b1;
    end else if (hdr_run_r && bit_strobe) begin
      hdr_cnt_r <= hdr_cnt_r + 5'h01;
      if (hdr_cnt_r == 5'(`RPA_TYPE_BIT)) hdr_run_r <= 1'b0;
    end
  end

  // device address match
  logic [47:0] sh_r;
  logic [5:0] bitn_r;
  logic type_r, dm_run_r, dm_hit_r, dm_miss_r;
  logic [7:0] hit_vec;
  wire little = packet_config_b_r[`RPA_ENDIAN_BIT] == 1'b0;
  wire [47:0] sh_nxt = {rx_bit, sh_r[47:1]};
  always_comb begin
    hit_vec = 8'h00;
    for (int i = 0; i < NUM_ADDR; i++) begin
      hit_vec[i] = dev_match_config_r[i] &&
        dev_match_config_r[8+i] == type_r &&
        sh_nxt == {dev_addr_high_part_r[i], dev_addr_low_part_r[i]};
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sh_r <= 48'h0;
      bitn_r <= 6'h00;
      type_r <= 1'b0;
      dm_run_r <= 1'b0;
      dm_hit_r <= 1'b0;
      dm_miss_r <= 1'b0;
    end else begin
      dm_hit_r <= 1'b0;
      dm_miss_r <= 1'b0;
      if (addr_event) type_r <= 1'b0;
      // header bit counted from address event
      if (payload_start && receiving && little) begin
        dm_run_r <= 1'b1;
        bitn_r <= 6'h00;
      end else if (dm_run_r && bit_strobe) begin
        sh_r <= sh_nxt;
        bitn_r <= bitn_r + 6'h01;
        if (bitn_r == 6'd47) begin
          dm_run_r <= 1'b0;
          dm_hit_r <= |hit_vec;
          dm_miss_r <= ~|hit_vec;
        end
      end
      if (hdr_strobe_6) type_r <= rx_bit;
    end
  end

  // bit counter
  logic [BC_W-1:0] bc_r;
  logic bc_run_r, addr_seen_r, bcm_r;
  wire bc_clear = wr_bcp || wr_stop || wr_dis || last_bit || disable_done;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bc_r <= '0;
      bc_run_r <= 1'b0;
      addr_seen_r <= 1'b0;
      bcm_r <= 1'b0;
    end else begin
      bcm_r <= 1'b0;
      if (addr_event) addr_seen_r <= 1'b1;
      else if (bc_clear) addr_seen_r <= 1'b0;
      if (bc_clear) begin
        bc_r <= '0;
        bc_run_r <= 1'b0;
      end else if (wr_bcs && (addr_seen_r || addr_event)) begin
        bc_run_r <= 1'b1;
        bc_r <= '0;
      end else if (bc_run_r && bit_strobe) begin
        bc_r <= bc_r + 1'b1;
        bcm_r <= bc_r + 1'b1 == bitcount_compare_r;
      end
    end
  end

  // packet layout: byte counts of each field
  function automatic logic [7:0] bytes_of(input logic [4:0] bits);
    bytes_of = 8'((6'(bits) + 6'd7) >> 3);
  endfunction
  wire [7:0] s0_b = {7'h00, packet_config_a_r[`RPA_S0_BIT]};
  wire [7:0] lf_b = bytes_of({1'b0, packet_config_a_r[`RPA_LF_LSB +: 4]});
  wire [7:0] s1_b = bytes_of({1'b0, packet_config_a_r[`RPA_S1_LSB +: 4]});
  wire [7:0] max_b = packet_config_b_r[`RPA_MAX_LSB +: 8];
  wire [7:0] stat_b = packet_config_b_r[`RPA_STAT_LSB +: 8];
  wire [8:0] want = {1'b0, length_value} + {1'b0, stat_b};
  logic [7:0] pay_r, crc_len_r, head_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pay_r <= 8'h00;
      crc_len_r <= 8'h00;
      head_r <= 8'h00;
    end else if (length_valid) begin
      head_r <= s0_b + lf_b + s1_b; // payload offset
      if (want > {1'b0, max_b}) begin
        pay_r <= max_b;
        crc_len_r <= max_b;
      end else begin
        pay_r <= want[7:0];
        crc_len_r <= length_value;
      end
    end
  end

  // events
  logic [5:0] evt_r;
  logic end_r, dis_r;
  wire [5:0] evt_set = {bcm_r, ss_done_r, dm_miss_r, dm_hit_r, dis_r, end_r};
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      end_r <= 1'b0;
      dis_r <= 1'b0;
      evt_r <= 6'h00;
    end else begin
      end_r <= last_bit;
      dis_r <= disable_done;
      evt_r <= (wr_evt ? evt_r & ~reg_wdata[5:0] : evt_r) | evt_set;
    end
  end

  // read back
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      `RPA_EVT_STATUS: rd_mux = {26'h0, evt_r};
      `RPA_SHORTCUTS: rd_mux = {28'h0, shortcut_enables_r};
      `RPA_PKT_PTR: rd_mux = ptr_r;
      `RPA_MODE: rd_mux = mode_r;
      `RPA_PKT_CFG_A: rd_mux = packet_config_a_r;
      `RPA_PKT_CFG_B: rd_mux = packet_config_b_r;
      `RPA_IFS: rd_mux = {16'h0, interframe_spacing_r};
      `RPA_SS_VALUE: rd_mux = 32'(ss_value_r);
      `RPA_BC_CMP: rd_mux = 32'(bitcount_compare_r);
      `RPA_DEV_CFG: rd_mux = {16'h0, dev_match_config_r};
      `RPA_ACTIVE_MODE: rd_mux = mode_act_r;
      `RPA_PKT_PTR_ACT: rd_mux = ptr_act_r;
      `RPA_PLAN: rd_mux = {8'h00, crc_len_r, pay_r, head_r};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_first_bit <= 1'b0;
      end_event <= 1'b0;
      disabled_event <= 1'b0;
      bitcount_match_event <= 1'b0;
      dev_match <= 1'b0;
      dev_miss <= 1'b0;
      crc_length <= 8'h00;
      active_ptr <= 32'h0;
    end else begin
      tx_first_bit <= tx_first_r;
      end_event <= end_r;
      disabled_event <= dis_r;
      bitcount_match_event <= bcm_r;
      dev_match <= dm_hit_r;
      dev_miss <= dm_miss_r;
      crc_length <= crc_len_r;
      active_ptr <= ptr_act_r;
    end
  end
endmodule

/* File: dv/rpa_engine_properties.sv */
// Purpose: port assertions for rpa_engine
// Assumes: one clock, async active low reset
// Notes: bound to every rpa_engine instance
`include "rpa_regs.svh"
module rpa_engine_props #(
  parameter int NUM_ADDR = 8,
  parameter int SS_W = 7,
  parameter int BC_W = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [SS_W-1:0] ss_level,
  input wire logic receiving,
  input wire logic bit_strobe,
  input wire logic rx_bit,
  input wire logic addr_event,
  input wire logic payload_start,
  input wire logic last_bit,
  input wire logic disable_done,
  input wire logic [7:0] length_value,
  input wire logic length_valid,
  input wire logic tx_first_bit,
  input wire logic end_event,
  input wire logic disabled_event,
  input wire logic bitcount_match_event,
  input wire logic dev_match,
  input wire logic dev_miss,
  input wire logic [7:0] crc_length,
  input wire logic [31:0] active_ptr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] gap_r;
  logic [7:0] pay_r;
  wire logic start_wr = reg_wr && reg_addr == `RPA_TASK_START;
  // cycles since the last bit on air, received or not
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) gap_r <= '0;
    else if (last_bit) gap_r <= '0;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h1;
  end
  // payload bits since payload start
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) pay_r <= '0;
    else if (payload_start) pay_r <= '0;
    else if (bit_strobe && pay_r != 8'hFF) pay_r <= pay_r + 8'h1;
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_two_on(e);
    ##1 !e ##1 e;
  endsequence
  a_end_after_last: assert property (last_bit |-> s_two_on(end_event))
    else $error("end event not two cycles after last bit");
  a_dis_after_done: assert property (disable_done |-> s_two_on(disabled_event))
    else $error("disabled event not two cycles after done");
  a_end_has_cause: assert property (end_event |-> $past(last_bit, 2))
    else $error("end event without last bit");
  a_bcm_on_strobe: assert property (bitcount_match_event |-> $past(bit_strobe, 2))
    else $error("bit count match without bit");
  a_match_in_rx: assert property ((dev_match || dev_miss) |-> $past(receiving, 2))
    else $error("address result outside reception");
  a_match_after_48: assert property ((dev_match || dev_miss) |-> pay_r == 8'd48)
    else $error("address result not after 48 bits");
  a_tx_after_turn: assert property (tx_first_bit |-> gap_r >= 16'd1598)
    else $error("first sent bit before turnaround");
  a_ptr_on_start: assert property ($changed(active_ptr) |-> $past(start_wr) || $past(start_wr, 2))
    else $error("active pointer moved without start");
endmodule
bind rpa_engine rpa_engine_props #(.NUM_ADDR(NUM_ADDR), .SS_W(SS_W), .BC_W(BC_W)) u_props (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ss_level(ss_level),
  .receiving(receiving), .bit_strobe(bit_strobe), .rx_bit(rx_bit),
  .addr_event(addr_event), .payload_start(payload_start), .last_bit(last_bit),
  .disable_done(disable_done), .length_value(length_value),
  .length_valid(length_valid), .tx_first_bit(tx_first_bit), .end_event(end_event),
  .disabled_event(disabled_event), .bitcount_match_event(bitcount_match_event),
  .dev_match(dev_match), .dev_miss(dev_miss), .crc_length(crc_length),
  .active_ptr(active_ptr));

/* File: dv/rpa_modem_model.sv */
// Purpose: modem side bit stream model for rpa_engine
// Assumes: pulses and strobes change right after rising mclk
// Notes: a released data line shows the inverse of its last bit
module rpa_modem_model (
  input wire logic mclk,
  output logic [6:0] ss_level,
  output logic receiving,
  output logic bit_strobe,
  output logic rx_bit,
  output logic addr_event,
  output logic payload_start,
  output logic last_bit,
  output logic disable_done,
  output logic [7:0] length_value,
  output logic length_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ss_level = 7'h2A;
    length_value = 8'h00;
    {receiving, bit_strobe, rx_bit, addr_event} = 4'h0;
    {payload_start, last_bit, disable_done, length_valid} = 4'h0;
  end
  // strength level seen by the receiver
  task automatic level(input logic [6:0] v);
    @(posedge mclk);
    ss_level <= v;
  endtask
  task automatic rx(input logic r);
    receiving <= r;
  endtask
  // k: 0 disable done, 1 last bit, 2 payload start, 3 address event
  task automatic pulse(input int k);
    @(posedge mclk);
    {addr_event, payload_start, last_bit, disable_done} <= 4'h1 << k;
    @(posedge mclk);
    {addr_event, payload_start, last_bit, disable_done} <= 4'h0;
  endtask
  task automatic bits(input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      bit_strobe <= 1'b1;
      rx_bit <= v[i];
      @(posedge mclk);
      bit_strobe <= 1'b0;
      rx_bit <= ~v[i];
    end
  endtask
  // header a with the type bit at 6, then the payload address
  task automatic frame(input logic [47:0] a, input logic t);
    rx(1'b1);
    pulse(3);
    bits({41'h0, t, 6'h00}, 8);
    pulse(2);
    bits(a, 48);
    repeat (4) @(posedge mclk);
    rx(1'b0);
  endtask
  // last bit on air, with or without reception
  task automatic last(input logic r);
    rx(r);
    pulse(1);
    rx(1'b0);
  endtask
  task automatic len(input logic [7:0] v, input logic s);
    @(posedge mclk);
    length_value <= v;
    length_valid <= s;
    @(posedge mclk);
    length_valid <= 1'b0;
    length_value <= ~v;
  endtask
endmodule

/* File: dv/rpa_engine_tb_top.sv */
// Purpose: self-checking bench for rpa_engine
// Assumes: modem model drives the bit stream side
// Notes: register tasks use the one-cycle strobe port
`include "rpa_regs.svh"
module rpa_engine_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] ADDR = 48'hC3A5_1234_5678;
  logic mclk, reset_n, reg_wr, reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, active_ptr, d;
  logic [6:0] ss_level;
  logic [7:0] length_value, crc_length;
  logic receiving, bit_strobe, rx_bit, addr_event, payload_start, last_bit;
  logic disable_done, length_valid, tx_first_bit, end_event, disabled_event;
  logic bitcount_match_event, dev_match, dev_miss;
  int bad_count, comparisons, n, e;
  int sc[5] = '{6, 6, 10, 2, 4};
  int ifs[5] = '{50, 10, 45, 50, 50};
  logic [11:0] cause[3] = '{`RPA_TASK_BC_STOP, `RPA_TASK_STOP, `RPA_TASK_DISABLE};
  rpa_engine uut (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ss_level(ss_level),
    .receiving(receiving), .bit_strobe(bit_strobe), .rx_bit(rx_bit),
    .addr_event(addr_event), .payload_start(payload_start), .last_bit(last_bit),
    .disable_done(disable_done), .length_value(length_value),
    .length_valid(length_valid), .tx_first_bit(tx_first_bit), .end_event(end_event),
    .disabled_event(disabled_event), .bitcount_match_event(bitcount_match_event),
    .dev_match(dev_match), .dev_miss(dev_miss), .crc_length(crc_length),
    .active_ptr(active_ptr));
  rpa_modem_model m (
    .mclk(mclk), .ss_level(ss_level), .receiving(receiving), .bit_strobe(bit_strobe),
    .rx_bit(rx_bit), .addr_event(addr_event), .payload_start(payload_start),
    .last_bit(last_bit), .disable_done(disable_done), .length_value(length_value),
    .length_valid(length_valid));
  always #12.5 mclk = ~mclk;
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  // masked event status after the two-cycle event latency
  task automatic ev(input logic [31:0] k, input logic [31:0] x, input string s);
    repeat (3) @(posedge mclk);
    rd(`RPA_EVT_STATUS);
    chk(s, x, d & k);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    {reg_wr, reg_rd} = 2'b00;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`RPA_EVT_STATUS);
    chk("events", 32'h0, d);
    wr(12'hFFC, 32'h5A);
    rd(12'hFFC);
    chk("unmapped", 32'h0, d);
    m.pulse(3);
    wr(`RPA_BC_CMP, 32'd5);
    wr(`RPA_TASK_BC_START, 32'h1);
    m.bits(48'h0, 8);
    ev(32'h20, 32'h20, "bc match");
    wr(`RPA_EVT_STATUS, 32'h3F);
    wr(`RPA_BC_CMP, 32'd12);
    m.bits(48'h0, 6);
    ev(32'h20, 32'h20, "bc again");
    for (int c = 0; c < 4; c++) begin
      wr(`RPA_EVT_STATUS, 32'h3F);
      m.pulse(3);
      wr(`RPA_BC_CMP, 32'd4);
      wr(`RPA_TASK_BC_START, 32'h1);
      m.bits(48'h0, 2);
      if (c < 3) wr(cause[c], 32'h1);
      else m.last(1'b0);
      if (c == 2) m.pulse(0);
      m.bits(48'h0, 3);
      ev(32'h23, c == 3 ? 32'h1 : (c == 2 ? 32'h2 : 32'h0), "bc cleared");
      m.pulse(3);
      wr(`RPA_TASK_BC_START, 32'h1);
    end
    for (int i = 0; i < 8; i++) begin
      wr(`RPA_DEV_LOW + 12'(4 * i), ADDR[31:0] ^ 32'(i));
      wr(`RPA_DEV_HIGH + 12'(4 * i), {16'h0, ADDR[47:32]});
    end
    for (int k = 0; k < 11; k++) begin
      wr(`RPA_DEV_CFG,
        k < 8 ? 32'h1 << k : (k == 8 ? 32'hFE : (k == 9 ? 32'hFF : 32'h1)));
      wr(`RPA_PKT_CFG_B, k == 9 ? 32'h0100_020A : 32'h0000_020A);
      wr(`RPA_EVT_STATUS, 32'h3F);
      m.frame(ADDR ^ 48'(k % 10 % 8), k == 10);
      ev(32'hC, k < 8 ? 32'h4 : (k == 9 ? 32'h0 : 32'h8), "dev match");
    end
    for (int t = 0; t < 2; t++) begin
      wr(`RPA_MODE, 32'(t + 1));
      rd(`RPA_ACTIVE_MODE);
      chk("mode held", 32'(t), d);
      wr(12'(4 * t), 32'h1);
      rd(`RPA_ACTIVE_MODE);
      chk("mode taken", 32'(t + 1), d);
    end
    wr(`RPA_PKT_PTR, 32'h2000_0100);
    repeat (3) @(negedge mclk);
    chk("ptr held", 32'h0, active_ptr);
    wr(`RPA_TASK_START, 32'h1);
    wr(`RPA_PKT_PTR, 32'h2000_0200);
    @(negedge mclk);
    chk("ptr taken", 32'h2000_0100, active_ptr);
    wr(`RPA_PKT_CFG_B, 32'h0000_020A);
    wr(`RPA_PKT_CFG_A, 32'h0009_0108);
    m.len(8'd20, 1'b1);
    repeat (3) @(negedge mclk);
    chk("crc cap", 32'd10, {24'h0, crc_length});
    rd(`RPA_PLAN);
    chk("plan cap", 32'h000A_0A04, d);
    m.len(8'd5, 1'b1);
    repeat (3) @(negedge mclk);
    chk("crc len", 32'd5, {24'h0, crc_length});
    rd(`RPA_PLAN);
    chk("plan", 32'h0005_0704, d);
    m.len(8'd99, 1'b0);
    repeat (3) @(negedge mclk);
    chk("crc kept", 32'd5, {24'h0, crc_length});
    m.level(7'h15);
    wr(`RPA_TASK_RX_RAMP, 32'h1);
    wr(`RPA_TASK_START, 32'h1);
    wr(`RPA_EVT_STATUS, 32'h3F);
    wr(`RPA_TASK_SS_START, 32'h1);
    repeat (`RPA_SS_CYC) @(posedge mclk);
    ev(32'h10, 32'h10, "ss end");
    rd(`RPA_SS_VALUE);
    chk("ss value", 32'h1, 32'(d >= 32'h12 && d <= 32'h15));
    wr(`RPA_EVT_STATUS, 32'h3F);
    repeat (40) @(posedge mclk);
    ev(32'h10, 32'h0, "ss once");
    wr(`RPA_SHORTCUTS, 32'hE);
    rd(`RPA_SHORTCUTS);
    chk("shortcuts", 32'hE, d);
    for (int j = 0; j < 5; j++) begin
      wr(`RPA_SHORTCUTS, 32'(sc[j]));
      wr(`RPA_IFS, 32'(ifs[j]));
      m.last(1'b1);
      n = 0;
      while (tx_first_bit !== 1'b1 && n < 2500) begin
        @(posedge mclk);
        #1 n++;
      end
      e = (ifs[j] < 40 ? 40 : ifs[j]) * `RPA_US_CYC + 2;
      if (sc[j] < 6) chk("no spacing", 32'h0, 32'(n < 2500));
      else chk("gap", 32'h1, 32'(n > e - 5 && n < e + 5));
      if (sc[j] >= 6 && n >= 2500) test_done;
    end
    test_done;
  end
endmodule
